// ==== logic/dlsi_pkg.sv ====
/*
  Constants, register map and state types of the three-channel line side interface.
  Assumes a 100 MHz system clock and a classic Wishbone master with 32-bit data.
*/
package dlsi_pkg;
  // ==========================================================================
  // Sizes and timing
  localparam int NCH = 3;
  localparam int CTL_W = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 100;
  localparam int RX_HALF_NS = 10;
  localparam int MON_HALF_NS = 10;
  localparam int RX_HALF_RAW = (RX_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int MON_HALF_RAW = (MON_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RX_HALF_CYC = 4'((RX_HALF_RAW < 1) ? 1 : RX_HALF_RAW);
  localparam logic [3:0] MON_HALF_CYC = 4'((MON_HALF_RAW < 1) ? 1 : MON_HALF_RAW);
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_GCTL = 8'h00;
  localparam logic [7:0] ADR_CCTL0 = 8'h04;
  localparam logic [7:0] ADR_STAT0 = 8'h10;
  // ==========================================================================
  // Field positions and reset values
  localparam int GB_LINE_EN = 0;
  localparam int GB_SOFT_RST = 1;
  localparam int CB_OUT_EN = 0;
  localparam int CB_SOFT_RST = 1;
  localparam int CB_RX_INV = 4;
  localparam int CB_TX_INV = 5;
  localparam int CB_RX_RAIL = 6;
  localparam int CB_TX_RAIL = 7;
  localparam int CB_E3 = 8;
  localparam int SB_SIGLOSS = 0;
  localparam int SB_OVERRUN = 1;
  localparam logic [1:0] GCTL_RST = 2'h0;
  localparam logic [CTL_W-1:0] CCTL_RST = 9'h000;
  localparam logic [3:0] B3ZS_KEEP = 4'h8;
  localparam logic [3:0] HDB3_KEEP = 4'h0;
  // ==========================================================================
  // Per-channel state
  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic prevClk;
    logic [3:0] marks;
    logic lastPol;
    logic bitValid;
    logic bitData;
    logic sigLoss;
    logic overrun;
    logic txNrz;
    logic txNrzValid;
    logic rxPos;
    logic rxNeg;
    logic rxClk;
    logic rxBusy;
    logic [3:0] rxCnt;
    logic monData;
    logic monClk;
    logic monBusy;
    logic [3:0] monCnt;
    logic oe;
  } dlsi_chan_t;
endpackage : dlsi_pkg

// ==== logic/dlsi_line_if.sv ====
/*
  Line side interface: Wishbone register slave, per-channel receive launch, transmit
  sampling and rail decoding, monitor FIFO and monitor clock generation.
  Assumes line clocks well below clk/4 and user-side strobes on the clk domain.
*/
`timescale 1ns/1ps
// ============================================================================
// Monitor FIFO, valid/ready on both sides
module dlsi_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  input wire logic [W-1:0] inData, // Write data
  output logic outValid, // Data available
  input wire logic outReady, // Read request
  output logic [W-1:0] outData // Read data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dlsi_fifo_t;
  dlsi_fifo_t fifo_ff;
  dlsi_fifo_t nxt_fifo;
  logic push;
  logic pop;

  // Flags straight from the count so full and empty never lie
  assign inReady = (fifo_ff.cnt != (AW+1)'(DEPTH));
  assign outValid = (fifo_ff.cnt != '0);
  assign outData = fifo_ff.mem[fifo_ff.rp];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // Pointer and count update
  always_comb begin
    nxt_fifo = fifo_ff;
    if (push) begin
      nxt_fifo.mem[fifo_ff.wp] = inData;
      nxt_fifo.wp = fifo_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_fifo.rp = fifo_ff.rp + 1'b1;
    end
    nxt_fifo.cnt = fifo_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_ff <= '0;
    end else if (ce) begin
      fifo_ff <= nxt_fifo;
    end
  end
endmodule : dlsi_fifo

// ============================================================================
// Top level
module dlsi_line_if
  import dlsi_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [NCH-1:0] rxPosIn, // Receive data or positive rail to launch
  input wire logic [NCH-1:0] rxNegIn, // Receive negative rail to launch
  input wire logic [NCH-1:0] rxStrobe, // Launch one receive bit
  output logic [NCH-1:0] rxLinePosData, // Receive positive rail or NRZ pin
  output logic [NCH-1:0] rxLineNegData, // Receive negative rail pin
  output logic [NCH-1:0] rxLineClock, // Receive line clock pin
  output logic [NCH-1:0] monitorDataOut, // Monitor NRZ data pin
  output logic [NCH-1:0] monitorClockOut, // Monitor clock pin
  output logic [NCH-1:0] lineOe, // Drive enable of the five line output pins
  input wire logic [NCH-1:0] txLinePosData, // Transmit positive rail or NRZ pin
  input wire logic [NCH-1:0] txLineNegOrSigloss, // Transmit negative rail or signal loss
  input wire logic [NCH-1:0] txLineClock, // Transmit line clock pin
  output logic [NCH-1:0] txNrzData, // Decoded transmit bit
  output logic [NCH-1:0] txNrzValid, // Decoded transmit bit strobe
  output logic [NCH-1:0] sigLossOut // Signal loss level in NRZ mode
);
  typedef struct packed {
    logic [1:0] gctl;
    logic ack;
    logic [31:0] rdData;
    dlsi_chan_t [NCH-1:0] chan;
  } dlsi_top_t;

  dlsi_top_t st_ff;
  dlsi_top_t nxt_st;
  logic [NCH-1:0] txEdge;
  logic [NCH-1:0] fifoInReady;
  logic [NCH-1:0] fifoOutValid;
  logic [NCH-1:0] fifoOutData;
  logic [NCH-1:0] fifoInValid;
  logic [NCH-1:0] fifoOutReady;
  logic [NCH-1:0] chanRst;

  // ==========================================================================
  // Monitor FIFOs and output pins
  // three channels
  for (genvar g = 0; g < NCH; g++) begin : gen_ch
    assign chanRst[g] = st_ff.gctl[GB_SOFT_RST] | st_ff.chan[g].ctl[CB_SOFT_RST];
    assign fifoInValid[g] = st_ff.chan[g].bitValid;
    assign fifoOutReady[g] = ~st_ff.chan[g].monBusy;
    dlsi_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .inValid(fifoInValid[g]),
      .inReady(fifoInReady[g]),
      .inData(st_ff.chan[g].bitData),
      .outValid(fifoOutValid[g]),
      .outReady(fifoOutReady[g]),
      .outData(fifoOutData[g])
    );
    assign rxLinePosData[g] = st_ff.chan[g].rxPos;
    assign rxLineNegData[g] = st_ff.chan[g].rxNeg;
    assign rxLineClock[g] = st_ff.chan[g].rxClk;
    assign monitorDataOut[g] = st_ff.chan[g].monData;
    assign monitorClockOut[g] = st_ff.chan[g].monClk;
    assign lineOe[g] = st_ff.chan[g].oe;
    assign txNrzData[g] = st_ff.chan[g].txNrz;
    assign txNrzValid[g] = st_ff.chan[g].txNrzValid;
    assign sigLossOut[g] = st_ff.chan[g].sigLoss;
  end
  assign wb_dat_o = st_ff.rdData;
  assign wb_ack_o = st_ff.ack;

  // ==========================================================================
  // Next state: bus slave first, so channel events set sticky bits after a clear
  always_comb begin
    logic chRst;
    logic mark;
    logic viol;
    logic outBit;
    logic inv;
    logic [3:0] m;
    logic [7:0] ofs;
    logic wr;
    logic rd;
    dlsi_chan_t keep;
    wr = 1'b0;
    rd = 1'b0;
    keep = '0;
    chRst = 1'b0;
    mark = 1'b0;
    viol = 1'b0;
    outBit = 1'b0;
    inv = 1'b0;
    m = 4'h0;
    ofs = 8'h00;
    nxt_st = st_ff;
    txEdge = '0;
    // Registered ack: one cycle after the request, then dropped for a cycle.
    // Writes land at the edge where the master sees ack; read data is loaded with ack.
    nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    wr = st_ff.ack & wb_cyc_i & wb_stb_i & wb_we_i;
    rd = nxt_st.ack & ~wb_we_i;
    if (rd) begin
      nxt_st.rdData = 32'h00000000;
    end
    if (wb_adr_i == ADR_GCTL) begin
      if (wr && wb_sel_i[0]) begin
        nxt_st.gctl = wb_dat_i[1:0];
      end else if (rd) begin
        nxt_st.rdData = {30'h0, st_ff.gctl};
      end
    end
    for (int i = 0; i < NCH; i++) begin
      ofs = 8'(4 * i);
      if (wb_adr_i == ADR_CCTL0 + ofs) begin
        if (wr) begin
          if (wb_sel_i[0]) begin
            nxt_st.chan[i].ctl[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            nxt_st.chan[i].ctl[CB_E3] = wb_dat_i[CB_E3];
          end
        end else if (rd) begin
          nxt_st.rdData = {23'h0, st_ff.chan[i].ctl};
        end
      end
      if (wb_adr_i == ADR_STAT0 + ofs) begin
        if (wr && wb_sel_i[0] && wb_dat_i[SB_OVERRUN]) begin
          nxt_st.chan[i].overrun = 1'b0; // Write one to clear
        end else if (rd) begin
          nxt_st.rdData = {30'h0, st_ff.chan[i].overrun, st_ff.chan[i].sigLoss};
        end
      end
    end
    // Per-channel datapath
    for (int i = 0; i < NCH; i++) begin
      chRst = chanRst[i];
      nxt_st.chan[i].oe = st_ff.gctl[GB_LINE_EN] & st_ff.chan[i].ctl[CB_OUT_EN] & ~chRst;
      // Pins pass two flops; only the second stage is read
      nxt_st.chan[i].sync1 = {txLineClock[i], txLineNegOrSigloss[i], txLinePosData[i]};
      nxt_st.chan[i].sync2 = st_ff.chan[i].sync1;
      nxt_st.chan[i].prevClk = st_ff.chan[i].sync2[2];
      // rising edge, falling edge when inverted
      txEdge[i] = (st_ff.chan[i].sync2[2] != st_ff.chan[i].prevClk)
                & (st_ff.chan[i].sync2[2] == ~st_ff.chan[i].ctl[CB_TX_INV]);
      nxt_st.chan[i].txNrzValid = 1'b0;
      if (st_ff.chan[i].bitValid && fifoInReady[i]) begin
        nxt_st.chan[i].bitValid = 1'b0;
      end
      // loss level only counts while the rails are off
      nxt_st.chan[i].sigLoss = ~st_ff.chan[i].ctl[CB_TX_RAIL] & st_ff.chan[i].sync2[1];
      if (txEdge[i]) begin
        mark = st_ff.chan[i].sync2[0] | st_ff.chan[i].sync2[1];
        if (st_ff.chan[i].ctl[CB_TX_RAIL]) begin
          // rails pass a four-bit delay so a substitution can be erased
          // a violation is a mark of the same polarity as the mark before it
          viol = mark & (st_ff.chan[i].sync2[0] == st_ff.chan[i].lastPol);
          outBit = st_ff.chan[i].marks[3];
          m = {st_ff.chan[i].marks[2:0], mark};
          if (viol) begin
            m = {st_ff.chan[i].marks[2:0], 1'b0};
            m = m & (st_ff.chan[i].ctl[CB_E3] ? HDB3_KEEP : B3ZS_KEEP);
          end
          nxt_st.chan[i].marks = m;
          if (mark) begin
            nxt_st.chan[i].lastPol = st_ff.chan[i].sync2[0];
          end
        end else begin
          // NRZ data goes straight through, no added latency
          outBit = st_ff.chan[i].sync2[0];
        end
        // both formats meet here; a bit the FIFO has not taken is lost.
        // The overrun set comes after the bus clear, so an event wins over a clear.
        nxt_st.chan[i].overrun = nxt_st.chan[i].overrun | nxt_st.chan[i].bitValid;
        nxt_st.chan[i].bitValid = 1'b1;
        nxt_st.chan[i].bitData = outBit;
        nxt_st.chan[i].txNrz = outBit;
        nxt_st.chan[i].txNrzValid = 1'b1;
      end
      // the clock takes its launch level together with the data and
      // returns after a half period; the idle level is the one just before a launch edge
      inv = st_ff.chan[i].ctl[CB_RX_INV];
      if (rxStrobe[i]) begin
        // positive rail or NRZ leaves on one pin
        nxt_st.chan[i].rxPos = rxPosIn[i];
        // negative rail pin held low without rails
        nxt_st.chan[i].rxNeg = st_ff.chan[i].ctl[CB_RX_RAIL] & rxNegIn[i];
        nxt_st.chan[i].rxClk = inv;
        nxt_st.chan[i].rxBusy = 1'b1;
        nxt_st.chan[i].rxCnt = 4'h0;
      end else if (st_ff.chan[i].rxBusy) begin
        nxt_st.chan[i].rxCnt = st_ff.chan[i].rxCnt + 4'h1;
        if (st_ff.chan[i].rxCnt == RX_HALF_CYC - 4'h1) begin
          nxt_st.chan[i].rxClk = ~inv;
          nxt_st.chan[i].rxBusy = 1'b0;
        end
      end else begin
        nxt_st.chan[i].rxClk = ~inv;
      end
      // monitor bit and rising clock leave together; the clock falls half a
      // period later and stays low a half period plus one clock before the next bit
      if (!st_ff.chan[i].monBusy) begin
        if (fifoOutValid[i]) begin
          nxt_st.chan[i].monData = fifoOutData[i];
          nxt_st.chan[i].monClk = 1'b1;
          nxt_st.chan[i].monBusy = 1'b1;
          nxt_st.chan[i].monCnt = 4'h0;
        end
      end else begin
        nxt_st.chan[i].monCnt = st_ff.chan[i].monCnt + 4'h1;
        if (st_ff.chan[i].monCnt == MON_HALF_CYC - 4'h1) begin
          nxt_st.chan[i].monClk = 1'b0;
        end
        if (st_ff.chan[i].monCnt == {MON_HALF_CYC[2:0], 1'b0} - 4'h1) begin
          nxt_st.chan[i].monBusy = 1'b0;
        end
      end
      // soft reset empties the datapath, drains the monitor FIFO one bit per clock (not cleared), and keeps control and synchronisers
      // so that leaving reset shows no false transmit clock edge
      if (chRst) begin
        keep = nxt_st.chan[i];
        nxt_st.chan[i] = '0;
        nxt_st.chan[i].ctl = keep.ctl;
        nxt_st.chan[i].sync1 = keep.sync1;
        nxt_st.chan[i].sync2 = keep.sync2;
        nxt_st.chan[i].prevClk = keep.prevClk;
      end
    end
  end

  // ==========================================================================
  // State register; ce low freezes everything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Checks, one set per channel
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < NCH; g++) begin : gen_chk
    sequence s_rx_launch;
      ce && rxStrobe[g] && !chanRst[g];
    endsequence
    sequence s_mon_launch;
      ce && !st_ff.chan[g].monBusy && fifoOutValid[g] && !chanRst[g];
    endsequence
    a_rx_data: assert property (
      s_rx_launch |=> rxLinePosData[g] == $past(rxPosIn[g]))
      else $error("receive data not launched");
    a_rx_neg_low: assert property (
      ce && rxStrobe[g] && !chanRst[g] && !st_ff.chan[g].ctl[CB_RX_RAIL] |=> !rxLineNegData[g])
      else $error("negative rail not low without rails");
    a_rx_launch_edge: assert property (
      s_rx_launch |=> rxLineClock[g] == $past(st_ff.chan[g].ctl[CB_RX_INV]))
      else $error("receive clock not at launch level");
    a_float_enable: assert property (
      ce && !(st_ff.gctl[GB_LINE_EN] && st_ff.chan[g].ctl[CB_OUT_EN]) |=> !lineOe[g])
      else $error("line outputs driven while disabled");
    a_float_reset: assert property (
      ce && chanRst[g] |=> !lineOe[g])
      else $error("line outputs driven during soft reset");
    a_loss_rails: assert property (
      ce && st_ff.chan[g].ctl[CB_TX_RAIL] |=> !sigLossOut[g])
      else $error("signal loss shown with rails on");
    a_tx_sample: assert property (
      ce && txEdge[g] && !chanRst[g] |=> txNrzValid[g])
      else $error("transmit edge gave no bit");
    a_mon_launch: assert property (
      s_mon_launch |=> monitorClockOut[g] && monitorDataOut[g] == $past(fifoOutData[g]))
      else $error("monitor bit not launched on rising clock");
  end
endmodule : dlsi_line_if

// ==== sim/dlsi_line_partner.sv ====
/* Line unit model: transmit clock, data rails and signal loss level.
   Assumes the bench calls send and setLoss; clock stands still between frames. */
`timescale 1ns/1ps
module dlsi_line_partner (
  output logic [2:0] txPos, // Transmit NRZ or positive rail
  output logic [2:0] txNeg, // Negative rail or loss level
  output logic [2:0] txClk // Transmit line clock, 80 ns
);
  bit pol [3];
  initial begin
    txPos = 3'h0;
    txNeg = 3'h0;
    txClk = 3'h0;
  end
  // loss level while rails are off
  task automatic setLoss(input int c, input logic v);
    txNeg[c] = v;
  endtask : setLoss
  // AMI marks alternate, so no substitution is ever seen
  task automatic send(input int c, input bit inv, input bit rail, input logic [15:0] d);
    txClk[c] = inv;
    pol[c] = 1'b0; // Each frame starts on a fresh line after a soft reset
    for (int i = 0; i < 16; i++) begin
      txPos[c] = rail ? d[i] & ~pol[c] : d[i];
      if (rail) txNeg[c] = d[i] & pol[c];
      if (rail) pol[c] ^= d[i];
      // data changes away from the sampling edge
      #40 txClk[c] = ~inv;
      #40 txClk[c] = inv;
    end
    // Released pins show no stale value
    txPos[c] = ~txPos[c];
    if (rail) txNeg[c] = ~txNeg[c];
  endtask : send
endmodule : dlsi_line_partner

// ==== sim/tb_ds3_e3_line_side_interface.sv ====
/* Bench of the line side interface: Wishbone registers, receive launch, transmit
   sampling, decoding and monitor output. Assumes the line unit model beside it. */
`timescale 1ns/1ps
module tb_ds3_e3_line_side_interface;
  import dlsi_pkg::*;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO;
  logic [2:0] rxPosIn, rxNegIn, rxStrobe, rxLinePosData, rxLineNegData, rxLineClock;
  logic [2:0] monitorDataOut, monitorClockOut, lineOe, txPos, txNeg, txClk;
  logic [2:0] txNrzData, txNrzValid, sigLossOut, rxOld, monOld;
  logic [1:0] rxQ [3][$];
  logic monQ [3][$];
  logic nrzQ [3][$];
  bit [2:0] rxInv;
  int failures, testsRun;
  dlsi_line_if uut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .rxPosIn(rxPosIn), .rxNegIn(rxNegIn), .rxStrobe(rxStrobe),
    .rxLinePosData(rxLinePosData), .rxLineNegData(rxLineNegData), .rxLineClock(rxLineClock),
    .monitorDataOut(monitorDataOut), .monitorClockOut(monitorClockOut), .lineOe(lineOe),
    .txLinePosData(txPos), .txLineNegOrSigloss(txNeg), .txLineClock(txClk),
    .txNrzData(txNrzData), .txNrzValid(txNrzValid), .sigLossOut(sigLossOut));
  dlsi_line_partner partner (.txPos(txPos), .txNeg(txNeg), .txClk(txClk));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Classic single cycle; the answer is awaited under a bound
  task automatic wb(input bit we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge clk); while (wbAck !== 1'b1 && ++n < 50);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    chk(n < 50, 1);
  endtask : wb
  task automatic rxBit(input int c, input bit rail);
    logic p, n;
    p = 1'($urandom);
    n = ~p & 1'($urandom);
    @(posedge clk);
    rxPosIn[c] <= p;
    rxNegIn[c] <= n;
    rxStrobe[c] <= 1'b1;
    rxQ[c].push_back({p, rail ? n : 1'b0});
    @(posedge clk);
    rxStrobe[c] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : rxBit
  // Receive pins sampled opposite the launch edge, monitor on falling clock
  always @(posedge clk) begin
    for (int c = 0; c < 3; c++) begin
      if (lineOe[c] && rxLineClock[c] === ~rxInv[c] && rxOld[c] === rxInv[c] && rxQ[c].size())
        chk({rxLinePosData[c], rxLineNegData[c]}, rxQ[c].pop_front());
      if (lineOe[c] && !monitorClockOut[c] && monOld[c] && monQ[c].size())
        chk(monitorDataOut[c], monQ[c].pop_front());
      if (txNrzValid[c] && nrzQ[c].size())
        chk(txNrzData[c], nrzQ[c].pop_front());
    end
    rxOld <= rxLineClock;
    monOld <= monitorClockOut;
  end
  initial begin
    #300000;
    failures++;
    report_and_stop();
  end
  initial begin
    logic [31:0] q, cw;
    logic [15:0] d;
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbDatI, rxPosIn, rxNegIn, rxStrobe} = '0;
    void'($urandom(32'h457f));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(lineOe, 0);
    wb(0, ADR_GCTL, 0, q);
    chk(q, 32'(GCTL_RST));
    wb(0, 8'hfc, 0, q);
    chk(q, 0);
    wb(1, ADR_GCTL, 32'h1 << GB_LINE_EN, q);
    for (int c = 0; c < 3; c++) begin
      wb(0, 8'(ADR_CCTL0 + 4 * c), 0, q);
      chk(q, 32'(CCTL_RST));
      for (int m = 0; m < 4; m++) begin
        rxQ[c].delete();
        monQ[c].delete();
        nrzQ[c].delete();
        rxInv[c] = 1'($urandom);
        cw = {m[1:0], 1'b0, rxInv[c], 3'h0, m != 0} | ($urandom & 32'h120);
        wb(1, 8'(ADR_CCTL0 + 4 * c), cw | 32'h2, q);
        repeat (4) @(posedge clk);
        chk(lineOe[c], 0);
        wb(1, 8'(ADR_CCTL0 + 4 * c), cw, q);
        wb(0, 8'(ADR_CCTL0 + 4 * c), 0, q);
        chk(q, cw);
        chk(lineOe[c], m != 0);
        partner.setLoss(c, 1'b1);
        repeat (8) @(posedge clk);
        chk(sigLossOut[c], !m[1]);
        partner.setLoss(c, 1'b0);
        d = {8'h00, 8'($urandom)};
        if (m[1]) begin
          // Rail decoding delays the stream by four leading zeros
          for (int i = 0; i < 4; i++) begin
            monQ[c].push_back(1'b0);
            nrzQ[c].push_back(1'b0);
          end
        end
        for (int i = 0; i < 16; i++) begin
          monQ[c].push_back(d[i]);
          nrzQ[c].push_back(d[i]);
        end
        fork
          partner.send(c, cw[5], m[1], d);
          repeat (16) rxBit(c, m[0]);
        join
        repeat (40) @(posedge clk);
      end
    end
    wb(1, ADR_GCTL, 32'h3, q);
    repeat (4) @(posedge clk);
    chk(lineOe, 0);
    report_and_stop();
  end
endmodule : tb_ds3_e3_line_side_interface
